// *** design/pin_sync.sv ***
/*
  Pin synchroniser and falling-edge finder for the count and gate pins.
  Assumes pins are asynchronous to ref_clk; outputs are registered.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [timer_pkg::NUM_PINS-1:0] pins_in,
  output logic      [timer_pkg::NUM_PINS-1:0] level,
  output logic      [timer_pkg::NUM_PINS-1:0] fall
);
  timer_pkg::sync_state_t         q;
  timer_pkg::sync_state_t         d;
  logic [timer_pkg::NUM_PINS-1:0] lvl_next;

  // a level is accepted only when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < timer_pkg::NUM_PINS; i++) begin : g_pin
      assign lvl_next[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.lvl[i];
    end
  endgenerate

  // one sample high then the next low gives a single count pulse
  always_comb begin
    d      = q;
    d.s1   = pins_in;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.lvl  = lvl_next;
    d.fall = q.lvl & ~lvl_next;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
  assign fall  = q.fall;
endmodule : pin_sync
`default_nettype wire

// *** design/timer_pkg.sv ***
/*
  Shared constants and types for the triple timer/counter block: register
  addresses, bit positions, reset values, mode codes and packed carriers.
  Assumes one 100 MHz core clock and a byte-wide special register port.
*/
package timer_pkg;

  // register addresses on the special register port
  localparam logic [7:0] ADDR_TIMER01_CONTROL    = 8'h88;
  localparam logic [7:0] ADDR_TIMER01_MODE       = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_COUNT_LOW   = 8'h8A;
  localparam logic [7:0] ADDR_TIMER1_COUNT_LOW   = 8'h8B;
  localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH  = 8'h8C;
  localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH  = 8'h8D;
  localparam logic [7:0] ADDR_TIMER2_CONTROL     = 8'hC8;
  localparam logic [7:0] ADDR_TIMER2_RELOAD_LOW  = 8'hCA;
  localparam logic [7:0] ADDR_TIMER2_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_TIMER2_COUNT_LOW   = 8'hCC;
  localparam logic [7:0] ADDR_TIMER2_COUNT_HIGH  = 8'hCD;

  // timer01_control bit positions
  localparam int TF1_BIT = 7;
  localparam int TR1_BIT = 6;
  localparam int TF0_BIT = 5;
  localparam int TR0_BIT = 4;

  // timer01_mode bit positions
  localparam int TIMER1_PIN_QUALIFY_BIT   = 7;
  localparam int SRC1_BIT    = 6;
  localparam int MODE1_MSB   = 5;
  localparam int MODE1_LSB   = 4;
  localparam int TIMER0_PIN_QUALIFY_BIT   = 3;
  localparam int SRC0_BIT    = 2;
  localparam int MODE0_MSB   = 1;
  localparam int MODE0_LSB   = 0;

  // timer2_control bit positions
  localparam int TF2_BIT   = 7;
  localparam int RXCLK_BIT = 5;
  localparam int TXCLK_BIT = 4;
  localparam int TR2_BIT   = 2;
  localparam int SRC2_BIT  = 1;

  // reset value, all-ones byte and prescaler top count
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ONES  = 8'hFF;
  localparam logic [4:0] PRESCALE_TOP = 5'h1F;

  // pin indices inside the synchroniser
  localparam int NUM_PINS  = 5;
  localparam int PIN_CNT0  = 0;
  localparam int PIN_CNT1  = 1;
  localparam int PIN_CNT2  = 2;
  localparam int PIN_TIMER0_PIN_QUALIFY = 3;
  localparam int PIN_TIMER1_PIN_QUALIFY = 4;

  typedef enum logic [1:0] {
    MODE_PRESCALE = 2'b00,
    MODE_CASCADE  = 2'b01,
    MODE_RELOAD   = 2'b10,
    MODE_SPLIT    = 2'b11
  } mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [7:0] tl;
    logic [7:0] th;
    logic       ovf;
  } step_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
    logic [NUM_PINS-1:0] s3;
    logic [NUM_PINS-1:0] lvl;
    logic [NUM_PINS-1:0] fall;
  } sync_state_t;

  typedef struct packed {
    logic [7:0] timer01_control;
    logic [7:0] timer01_mode;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [7:0] timer2_control;
    logic [7:0] rcap_l;
    logic [7:0] rcap_h;
    logic [7:0] tl2;
    logic [7:0] th2;
    logic [7:0] rdata;
  } timer_state_t;

endpackage : timer_pkg

// *** design/triple_timer_counter.sv ***
/*
  Three 16-bit timer/counters behind a byte-wide special register port.
  Assumes the core vectoring logic pulses vector_ack_* for one cycle and
  that count and gate pins are asynchronous and held two cycles per level.
*/
`timescale 1ns/10ps
`default_nettype none
module triple_timer_counter (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire timer_pkg::sfr_req_t sfr,
  output logic [7:0]               sfr_rdata,
  input  wire logic                count_input_zero,
  input  wire logic                count_input_one,
  input  wire logic                count_input_two,
  input  wire logic                gate_pin_zero,
  input  wire logic                gate_pin_one,
  input  wire logic                vector_ack_zero,
  input  wire logic                vector_ack_one,
  output logic                     timer0_overflow_flag,
  output logic                     timer1_overflow_flag,
  output logic                     timer2_overflow_flag
);
  timer_pkg::timer_state_t        q;
  timer_pkg::timer_state_t        d;
  logic [timer_pkg::NUM_PINS-1:0] pin_level;
  logic [timer_pkg::NUM_PINS-1:0] pin_fall;
  logic [timer_pkg::NUM_PINS-1:0] pins_raw;
  timer_pkg::mode_t               mode0;
  timer_pkg::mode_t               mode1;
  logic                           run0;
  logic                           run1;
  logic                           run2;
  logic                           tick0;
  logic                           tick1;
  logic                           tick2;
  logic                           split0;
  logic                           split_ovf;
  logic                           set_tf0;
  logic                           set_tf1;
  logic                           set_tf2;
  timer_pkg::step_t               step0;
  timer_pkg::step_t               step1;
  logic [15:0]                    t2_count;

  // one count step of timer 0 or 1; mode 11 leaves the bytes alone
  function automatic timer_pkg::step_t count_step(
    input timer_pkg::mode_t mode,
    input logic             tick,
    input logic [7:0]       tl,
    input logic [7:0]       th
  );
    timer_pkg::step_t r;
    r.tl  = tl;
    r.th  = th;
    r.ovf = 1'b0;
    if (tick) begin
      case (mode)
        timer_pkg::MODE_PRESCALE: begin
          // upper three low-byte bits are left untouched by the prescaler
          r.tl[4:0] = tl[4:0] + 5'h01;
          if (tl[4:0] == timer_pkg::PRESCALE_TOP) begin
            r.th  = th + 8'h01;
            r.ovf = (th == timer_pkg::BYTE_ONES);
          end
        end
        timer_pkg::MODE_CASCADE: begin
          {r.th, r.tl} = {th, tl} + 16'h0001;
          r.ovf        = ({th, tl} == 16'hFFFF);
        end
        timer_pkg::MODE_RELOAD: begin
          if (tl == timer_pkg::BYTE_ONES) begin
            r.tl  = th;
            r.ovf = 1'b1;
          end else begin
            r.tl = tl + 8'h01;
          end
        end
        timer_pkg::MODE_SPLIT: begin
          r.tl = tl;
        end
        default: begin
          r.tl = tl;
        end
      endcase
    end
    return r;
  endfunction : count_step

  assign pins_raw = {gate_pin_one, gate_pin_zero, count_input_two, count_input_one, count_input_zero};

  // pins enter through three flops; the source must hold levels two full cycles
  pin_sync u_pin_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pins_in (pins_raw),
    .level   (pin_level),
    .fall    (pin_fall)
  );

  // run qualification: run bit, optionally gated by the gate pin
  always_comb begin
    mode0  = timer_pkg::mode_t'(q.timer01_mode[timer_pkg::MODE0_MSB:timer_pkg::MODE0_LSB]);
    mode1  = timer_pkg::mode_t'(q.timer01_mode[timer_pkg::MODE1_MSB:timer_pkg::MODE1_LSB]);
    split0 = (mode0 == timer_pkg::MODE_SPLIT);
    run0   = q.timer01_control[timer_pkg::TR0_BIT]
             & (~q.timer01_mode[timer_pkg::TIMER0_PIN_QUALIFY_BIT] | pin_level[timer_pkg::PIN_TIMER0_PIN_QUALIFY]);
    run1   = q.timer01_control[timer_pkg::TR1_BIT]
             & (~q.timer01_mode[timer_pkg::TIMER1_PIN_QUALIFY_BIT] | pin_level[timer_pkg::PIN_TIMER1_PIN_QUALIFY]);
    run2   = q.timer2_control[timer_pkg::TR2_BIT];
  end

  // tick source: every clock, or one pulse per recognised falling edge
  always_comb begin
    tick0 = run0 & (q.timer01_mode[timer_pkg::SRC0_BIT] ? pin_fall[timer_pkg::PIN_CNT0] : 1'b1);
    tick1 = run1 & (q.timer01_mode[timer_pkg::SRC1_BIT] ? pin_fall[timer_pkg::PIN_CNT1] : 1'b1);
    tick2 = run2 & (q.timer2_control[timer_pkg::SRC2_BIT] ? pin_fall[timer_pkg::PIN_CNT2] : 1'b1);
  end

  // count steps for timers 0 and 1
  always_comb begin
    step0 = count_step(mode0, tick0, q.tl0, q.th0);
    step1 = count_step(mode1, tick1, q.tl1, q.th1);
    if (split0 && tick0) begin
      step0.tl  = q.tl0 + 8'h01;
      step0.ovf = (q.tl0 == timer_pkg::BYTE_ONES);
    end
  end

  // in split mode timer 0 high byte counts clocks under timer 1 run bit,
  // with no gate and no pin source, as a plain cycle timer
  always_comb begin
    split_ovf = 1'b0;
    if (split0 && q.timer01_control[timer_pkg::TR1_BIT]) begin
      split_ovf = (q.th0 == timer_pkg::BYTE_ONES);
    end
    set_tf0 = step0.ovf;
    // timer 1 gives up its flag to the borrowed high byte in split mode
    set_tf1 = split0 ? split_ovf : step1.ovf;
  end

  // timer 2: free 16-bit count with reload from the reload pair
  always_comb begin
    t2_count = {q.th2, q.tl2};
    set_tf2  = 1'b0;
    if (tick2) begin
      if (t2_count == 16'hFFFF) begin
        t2_count = {q.rcap_h, q.rcap_l};
        // serial clock use suppresses the overflow flag
        set_tf2  = ~(q.timer2_control[timer_pkg::RXCLK_BIT] | q.timer2_control[timer_pkg::TXCLK_BIT]);
      end else begin
        t2_count = t2_count + 16'h0001;
      end
    end
  end

  // next state: counting first, then software writes, then flag sets
  always_comb begin
    d     = q;
    d.tl0 = step0.tl;
    d.th0 = step0.th;
    d.tl1 = step1.tl;
    d.th1 = step1.th;
    d.tl2 = t2_count[7:0];
    d.th2 = t2_count[15:8];
    if (split0 && q.timer01_control[timer_pkg::TR1_BIT]) begin
      d.th0 = q.th0 + 8'h01;
    end
    // a write in the same cycle as a count step takes the written value
    if (sfr.wr) begin
      case (sfr.addr)
        timer_pkg::ADDR_TIMER01_CONTROL:    d.timer01_control   = sfr.wdata;
        timer_pkg::ADDR_TIMER01_MODE:       d.timer01_mode   = sfr.wdata;
        timer_pkg::ADDR_TIMER0_COUNT_LOW:   d.tl0    = sfr.wdata;
        timer_pkg::ADDR_TIMER1_COUNT_LOW:   d.tl1    = sfr.wdata;
        timer_pkg::ADDR_TIMER0_COUNT_HIGH:  d.th0    = sfr.wdata;
        timer_pkg::ADDR_TIMER1_COUNT_HIGH:  d.th1    = sfr.wdata;
        timer_pkg::ADDR_TIMER2_CONTROL:     d.timer2_control  = sfr.wdata;
        timer_pkg::ADDR_TIMER2_RELOAD_LOW:  d.rcap_l = sfr.wdata;
        timer_pkg::ADDR_TIMER2_RELOAD_HIGH: d.rcap_h = sfr.wdata;
        timer_pkg::ADDR_TIMER2_COUNT_LOW:   d.tl2    = sfr.wdata;
        timer_pkg::ADDR_TIMER2_COUNT_HIGH:  d.th2    = sfr.wdata;
        default: d.timer01_control = d.timer01_control; // unmapped writes are dropped
      endcase
    end
    // hardware set wins over vectoring clear and over a software write
    d.timer01_control[timer_pkg::TF0_BIT] = (d.timer01_control[timer_pkg::TF0_BIT] & ~vector_ack_zero) | set_tf0;
    d.timer01_control[timer_pkg::TF1_BIT] = (d.timer01_control[timer_pkg::TF1_BIT] & ~vector_ack_one) | set_tf1;
    d.timer2_control[timer_pkg::TF2_BIT] = d.timer2_control[timer_pkg::TF2_BIT] | set_tf2;
    // read data registered on the strobe; unmapped addresses answer zero
    if (sfr.rd) begin
      case (sfr.addr)
        timer_pkg::ADDR_TIMER01_CONTROL:    d.rdata = q.timer01_control;
        timer_pkg::ADDR_TIMER01_MODE:       d.rdata = q.timer01_mode;
        timer_pkg::ADDR_TIMER0_COUNT_LOW:   d.rdata = q.tl0;
        timer_pkg::ADDR_TIMER1_COUNT_LOW:   d.rdata = q.tl1;
        timer_pkg::ADDR_TIMER0_COUNT_HIGH:  d.rdata = q.th0;
        timer_pkg::ADDR_TIMER1_COUNT_HIGH:  d.rdata = q.th1;
        timer_pkg::ADDR_TIMER2_CONTROL:     d.rdata = q.timer2_control;
        timer_pkg::ADDR_TIMER2_RELOAD_LOW:  d.rdata = q.rcap_l;
        timer_pkg::ADDR_TIMER2_RELOAD_HIGH: d.rdata = q.rcap_h;
        timer_pkg::ADDR_TIMER2_COUNT_LOW:   d.rdata = q.tl2;
        timer_pkg::ADDR_TIMER2_COUNT_HIGH:  d.rdata = q.th2;
        default:                            d.rdata = timer_pkg::RESET_BYTE;
      endcase
    end
  end

  // single state register; every field clears on reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.timer01_mode   <= timer_pkg::RESET_BYTE;
      q.timer01_control   <= timer_pkg::RESET_BYTE;
      q.timer2_control  <= timer_pkg::RESET_BYTE;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata            = q.rdata;
  assign timer0_overflow_flag = q.timer01_control[timer_pkg::TF0_BIT];
  assign timer1_overflow_flag = q.timer01_control[timer_pkg::TF1_BIT];
  assign timer2_overflow_flag = q.timer2_control[timer_pkg::TF2_BIT];
endmodule : triple_timer_counter
`default_nettype wire

// *** testbench/pin_source.sv ***
/* count pin source: bursts of falling edges on one pin
   assumes go is raised only while busy is low */
`timescale 1ns/10ps
`default_nettype none
module pin_source (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] edges,
  output var  logic [2:0] pins,
  output var  logic       busy
);
  // pins idle high; each level held two or three cycles
  initial begin
    pins = 3'h7;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'b1;
        repeat (edges) begin
          pins[sel] <= 1'b0;
          repeat (2 + $urandom_range(1)) @(posedge ref_clk);
          pins[sel] <= 1'b1;
          repeat (2 + $urandom_range(1)) @(posedge ref_clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : pin_source
`default_nettype wire

// *** testbench/timer_checker.sv ***
/* port checker for the triple timer block
   assumes one clock domain; bound into the block's top module */
`timescale 1ns/10ps
`default_nettype none
module timer_checker (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire timer_pkg::sfr_req_t sfr,
  input wire logic [7:0]          sfr_rdata,
  input wire logic                vector_ack_zero,
  input wire logic                vector_ack_one,
  input wire logic                timer0_overflow_flag,
  input wire logic                timer1_overflow_flag,
  input wire logic                timer2_overflow_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] mode_q;
  logic [2:0] run_q;
  wire        w88 = sfr.wr && sfr.addr == 8'h88;
  wire        wc8 = sfr.wr && sfr.addr == 8'hC8;
  // shadow of bits only software changes, so reads can be predicted
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= 8'h00;
      run_q  <= 3'h0;
    end else begin
      if (sfr.wr && sfr.addr == 8'h89) mode_q <= sfr.wdata;
      if (w88) run_q[1:0] <= {sfr.wdata[6], sfr.wdata[4]};
      if (wc8) run_q[2] <= sfr.wdata[2];
    end
  end
  sequence rd_at(logic [7:0] a);
    sfr.rd && sfr.addr == a;
  endsequence
  chk_mode_read: assert property (rd_at(8'h89) |=> sfr_rdata == $past(mode_q))
    else $error("mode read wrong");
  chk_ctrl_read: assert property (
    rd_at(8'h88) |=> sfr_rdata[6:4] == {$past(run_q[1]), $past(timer0_overflow_flag), $past(run_q[0])})
    else $error("control read wrong");
  chk_unmapped_zero: assert property (rd_at(8'hC9) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!sfr.rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  chk_flag_write: assert property (w88 && sfr.wdata[5] && !vector_ack_zero |=> timer0_overflow_flag)
    else $error("flag write lost");
  chk_flag_hold: assert property (
    timer0_overflow_flag && !w88 && !vector_ack_zero |=> timer0_overflow_flag || $past(rst))
    else $error("flag dropped");
  chk_ack_clear: assert property (vector_ack_one && !run_q[1] && !w88 |=> !timer1_overflow_flag)
    else $error("ack did not clear flag");
  chk_stopped_quiet: assert property (!run_q[0] && !w88 |=> !$rose(timer0_overflow_flag))
    else $error("flag set while stopped");
  chk_t2_sticky: assert property (timer2_overflow_flag && !wc8 |=> timer2_overflow_flag)
    else $error("timer 2 flag lost");
endmodule : timer_checker
bind triple_timer_counter timer_checker timer_checker_inst (
  .ref_clk(ref_clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata), .vector_ack_zero(vector_ack_zero),
  .vector_ack_one(vector_ack_one),
  .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag),
  .timer2_overflow_flag(timer2_overflow_flag));
`default_nettype wire

// *** testbench/triple_timer_counter_bench.sv ***
/* self-checking bench for the triple timer block
   assumes the pin source model and the bound checker */
`timescale 1ns/10ps
`default_nettype none
module triple_timer_counter_bench;
  logic                ref_clk = 1'b0;
  logic                rst = 1'b1;
  timer_pkg::sfr_req_t sfr = '0;
  logic [7:0]          sfr_rdata, r, e, k [3];
  logic [2:0]          pins;
  wire  [2:0]          flags;
  logic [1:0]          gate = 2'h0, ack = 2'h0, sel = 2'h0;
  logic [7:0]          edges = 8'h00;
  logic [15:0]         c;
  logic                go = 1'b0, busy, pend = 1'b0;
  logic [7:0]          exp_q [$];
  int                  fail_count = 0, tests_run = 0, n, i, t;
  logic [7:0] adr [12] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
  // 100 MHz core clock
  always #5 ref_clk = ~ref_clk;
  triple_timer_counter triple_timer_counter_inst (
    .ref_clk(ref_clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .count_input_zero(pins[0]), .count_input_one(pins[1]), .count_input_two(pins[2]),
    .gate_pin_zero(gate[0]), .gate_pin_one(gate[1]), .vector_ack_zero(ack[0]), .vector_ack_one(ack[1]),
    .timer0_overflow_flag(flags[0]), .timer1_overflow_flag(flags[1]), .timer2_overflow_flag(flags[2]));
  pin_source pin_source_inst (
    .ref_clk(ref_clk), .go(go), .sel(sel), .edges(edges), .pins(pins), .busy(busy));
  task automatic give_verdict;
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // one request per call, idle cycle between, reads note their expectation
  task automatic access(input logic w, input logic [7:0] a, d);
    if (!w) exp_q.push_back(d);
    @(posedge ref_clk);
    sfr <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    sfr <= '0;
  endtask : access
  // timers held by gate bits with gate pins low; mode writes start and stop
  task automatic run_case(input logic [7:0] off, on, lo, hi, input int m);
    access(1'b1, 8'h89, off);
    for (int j = 2; j < 6; j++) access(1'b1, adr[j], (j > 3) ? hi : lo);
    access(1'b1, 8'h88, 8'h50);
    access(1'b1, 8'h89, on);
    repeat (m) @(posedge ref_clk);
    access(1'b1, 8'h89, off);
  endtask : run_case
  task automatic expect4(input logic [7:0] l0, h0, l1, h1, tc);
    access(1'b0, 8'h8A, l0);
    access(1'b0, 8'h8C, h0);
    access(1'b0, 8'h8B, l1);
    access(1'b0, 8'h8D, h1);
    access(1'b0, 8'h88, tc);
  endtask : expect4
  // read data appears the cycle after the read is taken
  always @(posedge ref_clk) begin
    if (pend) begin
      e = exp_q.pop_front();
      tests_run++;
      if (sfr_rdata !== e) begin
        fail_count++;
        $display("[ERR] sfr_rdata expected %h seen %h", e, sfr_rdata);
      end
    end
    pend <= sfr.rd;
  end
  initial begin
    n = $urandom(48366);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (adr[j]) access(1'b0, adr[j], 8'h00);
    // byte registers keep what software writes
    for (i = 2; i < 11; i++) begin
      if (i != 6) begin
        r = 8'($urandom);
        access(1'b1, adr[i], r);
        access(1'b0, adr[i], r);
      end
    end
    // software sets flags; vectoring clears those of timers 0 and 1
    access(1'b1, 8'h88, 8'hAF);
    access(1'b1, 8'hC8, 8'h80);
    @(posedge ref_clk);
    ack <= 2'h3;
    @(posedge ref_clk);
    ack <= 2'h0;
    access(1'b0, 8'h88, 8'h0F);
    access(1'b0, 8'hC8, 8'h80);
    // flag pins: only the software-only timer 2 flag survives vectoring
    tests_run++;
    if (flags !== 3'h4) begin
      fail_count++;
      $display("[ERR] flags expected %h seen %h", 3'h4, flags);
    end
    access(1'b1, 8'hC8, 8'h00);
    n = $urandom_range(200);
    c = 16'(n + 2);
    run_case(8'h99, 8'h11, 8'h00, 8'h00, n);
    expect4(c[7:0], c[15:8], c[7:0], c[15:8], 8'h50);
    n = $urandom_range(40);
    c = 16'(n + 32);
    run_case(8'h88, 8'h00, 8'hFE, 8'hFF, n);
    expect4({3'h7, c[4:0]}, 8'hFF + c[12:5], {3'h7, c[4:0]}, 8'hFF + c[12:5], 8'hF0);
    run_case(8'hAA, 8'h22, 8'hFE, 8'h80, 3);
    expect4(8'h83, 8'h80, 8'h83, 8'h80, 8'hF0);
    run_case(8'h39, 8'h33, 8'h00, 8'hFF, 0);
    expect4(8'h02, 8'h01, 8'h00, 8'hFF, 8'hD0);
    // gate pin high lets timer 0 run, low holds timer 1
    access(1'b1, 8'h88, 8'h00);
    gate <= 2'h1;
    access(1'b1, 8'h8A, 8'h00);
    access(1'b1, 8'h89, 8'h99);
    access(1'b1, 8'h88, 8'h50);
    repeat (n) @(posedge ref_clk);
    access(1'b1, 8'h88, 8'h00);
    c = 16'(n + 2);
    expect4(c[7:0], 8'h01, 8'h00, 8'hFF, 8'h00);
    // pin edges advance only the selected counter
    access(1'b1, 8'h8A, 8'h00);
    access(1'b1, 8'hCC, 8'h00);
    access(1'b1, 8'h89, 8'h55);
    access(1'b1, 8'hC8, 8'h06);
    access(1'b1, 8'h88, 8'h50);
    for (i = 0; i < 3; i++) begin
      k[i] = 8'(1 + $urandom_range(9));
      sel <= 2'(i);
      edges <= k[i];
      go <= 1'b1;
      repeat (2) @(posedge ref_clk);
      go <= 1'b0;
      for (t = 0; busy && t < 500; t++) @(posedge ref_clk);
      if (busy) begin
        fail_count++;
        give_verdict();
      end
      repeat (8) @(posedge ref_clk);
    end
    access(1'b1, 8'h88, 8'h00);
    access(1'b1, 8'hC8, 8'h00);
    access(1'b0, 8'h8A, k[0]);
    access(1'b0, 8'h8B, k[1]);
    access(1'b0, 8'hCC, k[2]);
    repeat (3) @(posedge ref_clk);
    give_verdict();
  end
endmodule : triple_timer_counter_bench
`default_nettype wire
